// *** pic_cfg.svh ***
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// register byte addresses
`define PIC_ADDR_CTRL 12'h000
`define PIC_ADDR_STATUS 12'h004

// control field positions
`define PIC_CTRL_IN_LATCH 0
`define PIC_CTRL_IN_CLKINV 1
`define PIC_CTRL_OUT_CLKINV 2
`define PIC_CTRL_CEUSE_LO 3
`define PIC_CTRL_CE_CONN 5
`define PIC_CTRL_IN_PRESET 6
`define PIC_CTRL_OUT_PRESET 7
`define PIC_CTRL_PATH1_REG 8
`define PIC_CTRL_PATH2_REG 9
`define PIC_CTRL_DELAY_LO 10
`define PIC_CTRL_DIR_LO 12
`define PIC_CTRL_OUT_REG 14
`define PIC_CTRL_WIDTH 15

// status field positions
`define PIC_STAT_PIN 0
`define PIC_STAT_IN_Q 1
`define PIC_STAT_OUT_Q 2
`define PIC_STAT_PATH1 3
`define PIC_STAT_PATH2 4
`define PIC_STAT_DELAY_LO 5
`define PIC_STAT_OE 7

// reset values of the configuration
`define PIC_RST_CEUSE 2'h3
`define PIC_RST_DELAY 2'h0
`define PIC_RST_DIR 2'h3
`define PIC_RST_PRESET 1'h0

`endif

// *** pic_pkg.sv ***
package pic_pkg;

    typedef enum logic [1:0] {
        PIC_CE_INPUT = 2'b01,
        PIC_CE_OUTPUT = 2'b10,
        PIC_CE_BOTH = 2'b11
    } pic_ceuse_e;

    typedef enum logic [1:0] {
        PIC_DLY_FULL = 2'b00,
        PIC_DLY_MED = 2'b01,
        PIC_DLY_ZERO = 2'b10
    } pic_delay_e;

    typedef enum logic [1:0] {
        PIC_DIR_IN = 2'b01,
        PIC_DIR_OUT = 2'b10,
        PIC_DIR_BIDIR = 2'b11
    } pic_dir_e;

endpackage

// *** pic_store.sv ***
`timescale 1ns/1ps
// storage element: rising-edge flop or transparent-high latch
module pic_store #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clkLvl,
    input wire logic invClk,
    input wire logic latchMode,
    input wire logic enable,
    input wire logic d,
    input wire logic globalSetReset,
    input wire logic preset,
    output logic q
);

    logic q_reg;
    logic q_next;
    logic prevClk_reg;
    wire logic effClk;
    wire logic riseEdge;
    wire logic flopLoad;
    wire logic latchOpen;

    // optional inverted clock or gate
    assign effClk = clkLvl ^ invClk;
    assign riseEdge = effClk & ~prevClk_reg;
    // flop: load on rising edge with enable high
    assign flopLoad = ~latchMode & riseEdge & enable;
    // latch: follow data while gate high and enabled
    assign latchOpen = latchMode & effClk & enable;

    // set/reset wins over clock, enable and data
    // enable low holds in both modes
    assign q_next = globalSetReset ? preset :
                    (flopLoad | latchOpen) ? d : q_reg;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            q_reg <= RESET_VAL;
            prevClk_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
            prevClk_reg <= effClk;
        end
    end

    assign q = q_reg;

endmodule

// *** pic_pin_io_cell.sv ***
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "pic_cfg.svh"

// Overview of operation
// - one pin: input, output or bidirectional
// - two array paths, direct or registered
// - input element: rising flop or latch
// - latch transparent while gate high, holds otherwise
// - clock inversion options; flop and latch combine
// - one shared enable, applied per configuration
// - enable fixed active high, never inverted
// - set/reset loads preset; zero by default
// - enabled flop takes data on rising edge
// - unconnected enable is high; low holds
// - selectable data delay, largest by default
// - variant one: one tap, on or off
// - variant two: full, medium or zero
module pic_pin_io_cell #(
    parameter bit TWO_TAP = 1'b1,
    parameter bit IN_LATCH = 1'b0,
    parameter bit IN_CLKINV = 1'b0,
    parameter bit OUT_CLKINV = 1'b0,
    parameter logic [1:0] CE_USE = `PIC_RST_CEUSE,
    parameter bit CE_CONNECTED = 1'b1,
    parameter logic IN_PRESET = `PIC_RST_PRESET,
    parameter logic OUT_PRESET = `PIC_RST_PRESET,
    parameter bit PATH1_REG = 1'b0,
    parameter bit PATH2_REG = 1'b1,
    parameter logic [1:0] DELAY_SEL = `PIC_RST_DELAY,
    parameter logic [1:0] DIR_MODE = `PIC_RST_DIR,
    parameter bit OUT_REG = 1'b0
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    input wire logic storeClk,
    input wire logic outClk,
    input wire logic cellClockEnable,
    input wire logic globalSetReset,
    input wire logic outData,
    input wire logic outTristate,
    output logic firstArrayInput,
    output logic secondArrayInput
);

    localparam logic [`PIC_CTRL_WIDTH-1:0] CTRL_RST = {
        OUT_REG,
        DIR_MODE,
        DELAY_SEL,
        PATH2_REG,
        PATH1_REG,
        OUT_PRESET,
        IN_PRESET,
        CE_CONNECTED,
        CE_USE,
        OUT_CLKINV,
        IN_CLKINV,
        IN_LATCH
    };

    // configuration register
    logic [`PIC_CTRL_WIDTH-1:0] ctrl_reg;
    logic [`PIC_CTRL_WIDTH-1:0] ctrl_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // pin synchroniser and cleaned level
    logic pinSync1_reg;
    logic pinSync2_reg;
    logic pinSync3_reg;
    logic pinClean_reg;
    logic pinClean_next;

    // registered outputs
    logic first_reg;
    logic first_next;
    logic second_reg;
    logic second_next;
    logic pinOut_reg;
    logic pinOut_next;
    logic pinOe_reg;
    logic pinOe_next;

    // decoded configuration
    wire logic cfgInLatch;
    wire logic cfgInClkInv;
    wire logic cfgOutClkInv;
    wire logic [1:0] cfgCeUseRaw;
    wire logic cfgCeConn;
    wire logic cfgInPreset;
    wire logic cfgOutPreset;
    wire logic cfgPath1Reg;
    wire logic cfgPath2Reg;
    wire logic [1:0] cfgDelayRaw;
    wire logic [1:0] cfgDirRaw;
    wire logic cfgOutReg;

    pic_pkg::pic_ceuse_e ceUse;
    pic_pkg::pic_delay_e delayEff;
    pic_pkg::pic_dir_e dirMode;

    wire logic ceLevel;
    wire logic ceIn;
    wire logic ceOut;
    wire logic delayedPin;
    wire logic inQ;
    wire logic outQ;
    wire logic dirAllowsIn;
    wire logic dirAllowsOut;

    // bus decode
    wire logic apbSetup;
    wire logic apbAccess;
    wire logic selCtrl;
    wire logic selStatus;
    wire logic addrMapped;
    wire logic ctrlWrite;
    wire logic [31:0] ctrlWord;
    wire logic [31:0] statusWord;
    wire logic [31:0] readWord;
    wire logic [31:0] byteMask;
    wire logic [31:0] ctrlMerged;

    assign cfgInLatch = ctrl_reg[`PIC_CTRL_IN_LATCH];
    assign cfgInClkInv = ctrl_reg[`PIC_CTRL_IN_CLKINV];
    assign cfgOutClkInv = ctrl_reg[`PIC_CTRL_OUT_CLKINV];
    assign cfgCeUseRaw = ctrl_reg[`PIC_CTRL_CEUSE_LO +: 2];
    assign cfgCeConn = ctrl_reg[`PIC_CTRL_CE_CONN];
    assign cfgInPreset = ctrl_reg[`PIC_CTRL_IN_PRESET];
    assign cfgOutPreset = ctrl_reg[`PIC_CTRL_OUT_PRESET];
    assign cfgPath1Reg = ctrl_reg[`PIC_CTRL_PATH1_REG];
    assign cfgPath2Reg = ctrl_reg[`PIC_CTRL_PATH2_REG];
    assign cfgDelayRaw = ctrl_reg[`PIC_CTRL_DELAY_LO +: 2];
    assign cfgDirRaw = ctrl_reg[`PIC_CTRL_DIR_LO +: 2];
    assign cfgOutReg = ctrl_reg[`PIC_CTRL_OUT_REG];

    // enable use; an empty code means both
    always_comb begin
        unique case (cfgCeUseRaw)
            2'b01: ceUse = pic_pkg::PIC_CE_INPUT;
            2'b10: ceUse = pic_pkg::PIC_CE_OUTPUT;
            default: ceUse = pic_pkg::PIC_CE_BOTH;
        endcase
    end

    // delay choice; medium only with two taps, else largest
    always_comb begin
        unique case (cfgDelayRaw)
            2'b01: delayEff = TWO_TAP ? pic_pkg::PIC_DLY_MED
                                      : pic_pkg::PIC_DLY_FULL;
            2'b10: delayEff = pic_pkg::PIC_DLY_ZERO;
            default: delayEff = pic_pkg::PIC_DLY_FULL;
        endcase
    end

    // pin direction; an empty code means input
    always_comb begin
        unique case (cfgDirRaw)
            2'b10: dirMode = pic_pkg::PIC_DIR_OUT;
            2'b11: dirMode = pic_pkg::PIC_DIR_BIDIR;
            default: dirMode = pic_pkg::PIC_DIR_IN;
        endcase
    end

    assign dirAllowsIn = (dirMode != pic_pkg::PIC_DIR_OUT);
    assign dirAllowsOut = (dirMode != pic_pkg::PIC_DIR_IN);

    // enable: no inversion; unconnected reads as high
    assign ceLevel = cfgCeConn ? cellClockEnable : 1'b1;
    // one enable shared by both elements
    assign ceIn = (ceUse == pic_pkg::PIC_CE_OUTPUT) ? 1'b1 : ceLevel;
    assign ceOut = (ceUse == pic_pkg::PIC_CE_INPUT) ? 1'b1 : ceLevel;

    // pin level after synchroniser; counts once stages agree
    assign pinClean_next = (pinSync2_reg == pinSync3_reg) ? pinSync3_reg
                                                          : pinClean_reg;

    // delay taps are settling time only; capture cycle unchanged
    assign delayedPin = pinClean_reg & dirAllowsIn;

    // input element with its own mode and clock sense
    pic_store #(
        .RESET_VAL(IN_PRESET)
    ) u_inStore (
        .clock(clock),
        .arst_n(arst_n),
        .clkLvl(storeClk),
        .invClk(cfgInClkInv),
        .latchMode(cfgInLatch),
        .enable(ceIn),
        .d(delayedPin),
        .globalSetReset(globalSetReset),
        .preset(cfgInPreset),
        .q(inQ)
    );

    // output element, always a flop, same enable
    pic_store #(
        .RESET_VAL(OUT_PRESET)
    ) u_outStore (
        .clock(clock),
        .arst_n(arst_n),
        .clkLvl(outClk),
        .invClk(cfgOutClkInv),
        .latchMode(1'b0),
        .enable(ceOut),
        .d(outData),
        .globalSetReset(globalSetReset),
        .preset(cfgOutPreset),
        .q(outQ)
    );

    // each array path picks direct or stored value
    assign first_next = cfgPath1Reg ? inQ : delayedPin;
    assign second_next = cfgPath2Reg ? inQ : delayedPin;

    // output side: direct or stored, active-high three-state
    assign pinOut_next = cfgOutReg ? outQ : outData;
    assign pinOe_next = dirAllowsOut & ~outTristate;

    // bus decode, zero wait states
    assign apbSetup = psel & ~penable;
    assign apbAccess = psel & penable;
    assign selCtrl = (paddr == `PIC_ADDR_CTRL);
    assign selStatus = (paddr == `PIC_ADDR_STATUS);
    assign addrMapped = selCtrl | selStatus;
    assign ctrlWrite = apbAccess & pwrite & selCtrl;

    assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign ctrlWord = {{(32-`PIC_CTRL_WIDTH){1'b0}}, ctrl_reg};
    assign ctrlMerged = (pwdata & byteMask) | (ctrlWord & ~byteMask);
    // settings change only by software writes
    assign ctrl_next = ctrlWrite ? ctrlMerged[`PIC_CTRL_WIDTH-1:0] : ctrl_reg;

    assign statusWord = {
        24'h0000_00,
        pinOe_reg,
        delayEff,
        second_reg,
        first_reg,
        outQ,
        inQ,
        pinClean_reg
    };

    assign readWord = selCtrl ? ctrlWord :
                      selStatus ? statusWord : 32'h0000_0000;
    assign prdata_next = (apbSetup & ~pwrite) ? readWord : prdata_reg;

    assign pready = 1'b1;
    assign pslverr = apbAccess & ~addrMapped;
    assign prdata = prdata_reg;

    // pin input: three-stage synchroniser
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinSync1_reg <= 1'b0;
            pinSync2_reg <= 1'b0;
            pinSync3_reg <= 1'b0;
            pinClean_reg <= 1'b0;
        end else begin
            pinSync1_reg <= pinIn;
            pinSync2_reg <= pinSync1_reg;
            pinSync3_reg <= pinSync2_reg;
            pinClean_reg <= pinClean_next;
        end
    end

    // array paths and pin drive
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            first_reg <= 1'b0;
            second_reg <= 1'b0;
            pinOut_reg <= 1'b0;
            pinOe_reg <= 1'b0;
        end else begin
            first_reg <= first_next;
            second_reg <= second_next;
            pinOut_reg <= pinOut_next;
            pinOe_reg <= pinOe_next;
        end
    end

    // configuration and read data
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= CTRL_RST;
            prdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            prdata_reg <= prdata_next;
        end
    end

    assign firstArrayInput = first_reg;
    assign secondArrayInput = second_reg;
    assign pinOut = pinOut_reg;
    assign pinOe = pinOe_reg;

endmodule

// *** pic_properties.sv ***
`timescale 1ns/1ps
module pic_props (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pinIn,
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic storeClk,
    input wire logic cellClockEnable,
    input wire logic globalSetReset,
    input wire logic outData,
    input wire logic outTristate,
    input wire logic firstArrayInput,
    input wire logic secondArrayInput
);
    logic [14:0] ctrl_reg;
    logic [2:0] up_reg;
    wire wrCtrl = psel && penable && pwrite && paddr == 12'h000;
    wire effClk = storeClk ^ ctrl_reg[1];
    wire useIn = ctrl_reg[5] && ctrl_reg[4:3] != 2'b10;
    wire go = (cellClockEnable || !useIn) && !globalSetReset && ctrl_reg[9]
        && ctrl_reg[13:12] != 2'b10;
    // shadow of the control word
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= 15'h3238;
            up_reg <= 3'h0;
        end else begin
            if (wrCtrl) begin
                ctrl_reg <= {pstrb[1] ? pwdata[14:8] : ctrl_reg[14:8],
                    pstrb[0] ? pwdata[7:0] : ctrl_reg[7:0]};
            end
            if (up_reg != 3'h7) begin
                up_reg <= up_reg + 3'h1;
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence steady;
        ($stable(pinIn) && $stable(ctrl_reg) && up_reg == 3'h7) [*6];
    endsequence
    sequence gsrHeld;
        (globalSetReset && ctrl_reg[9] && $stable(ctrl_reg)) [*2];
    endsequence
    property grab(trig);
        steady ##0 trig && go |-> ##2 secondArrayInput == $past(pinIn, 2);
    endproperty
    direct_path_a: assert property (steady ##0 !ctrl_reg[8]
        && ctrl_reg[13:12] != 2'b10 |-> firstArrayInput == pinIn)
        else $error("direct path differs from pin");
    flop_capture_a: assert property (grab(!ctrl_reg[0] && effClk && !$past(effClk)))
        else $error("flop missed capture");
    latch_follow_a: assert property (grab(ctrl_reg[0] && effClk))
        else $error("latch not transparent");
    enable_hold_a: assert property ((useIn && !cellClockEnable && !globalSetReset
        && ctrl_reg[9]) [*4] |-> $stable(secondArrayInput))
        else $error("disabled element changed");
    clock_low_hold_a: assert property ((!ctrl_reg[0] && !effClk && !globalSetReset
        && ctrl_reg[9]) [*4] |-> $stable(secondArrayInput))
        else $error("flop changed without edge");
    gsr_preset_a: assert property (gsrHeld |=> secondArrayInput == $past(ctrl_reg[6], 2))
        else $error("set/reset value wrong");
    pin_drive_a: assert property (1'b1 |=> pinOe == $past(ctrl_reg[13] && !outTristate))
        else $error("pin enable wrong");
    pin_data_a: assert property (!ctrl_reg[14] |=> pinOut == $past(outData))
        else $error("pin data wrong");
    delay_report_a: assert property (psel && penable && !pwrite && paddr == 12'h004
        |-> prdata[6:5] == (ctrl_reg[11:10] == 2'b11 ? 2'b00 : ctrl_reg[11:10]))
        else $error("delay field wrong");
endmodule
bind pic_pin_io_cell pic_props propsChk (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pinIn, .pinOut, .pinOe, .storeClk, .cellClockEnable,
    .globalSetReset, .outData, .outTristate, .firstArrayInput, .secondArrayInput);

// *** pic_pin_model.sv ***
`timescale 1ns/1ps
// outside driver; the cell wins while it drives, a released pin wanders
module pic_pin_model (
    input wire logic clock,
    input wire logic drvOn,
    input wire logic drvLvl,
    input wire logic pinOut,
    input wire logic pinOe,
    output logic pinIn
);
    logic float_reg = 1'b0;
    always @(posedge clock) float_reg <= !float_reg;
    assign pinIn = pinOe ? pinOut : (drvOn ? drvLvl : float_reg);
endmodule

// *** pic_pin_io_cell_tb_top.sv ***
`timescale 1ns/1ps
module pic_pin_io_cell_tb_top;
    logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err, pinIn, pinOut, pinOe;
    logic storeClk, outClk, cellClockEnable, globalSetReset, outData, outTristate, drvOn;
    logic drvLvl, firstArrayInput, secondArrayInput;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    int n_fail, samples_checked;
    pic_pin_io_cell dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe, .storeClk, .outClk,
        .cellClockEnable, .globalSetReset, .outData, .outTristate, .firstArrayInput,
        .secondArrayInput);
    pic_pin_model pinSide (.clock, .drvOn, .drvLvl, .pinOut, .pinOe, .pinIn);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [31:0] d);
        apb(1'b1, 12'h000, d);
    endtask
    task automatic pin(input logic v);
        drvLvl <= v;
        tick(6);
    endtask
    task automatic pulse();
        storeClk <= 1'b1;
        tick(1);
        storeClk <= 1'b0;
        tick(3);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        tick(3000);
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [1:0] dx [4];
        dx = '{pic_pkg::PIC_DLY_FULL, pic_pkg::PIC_DLY_MED, pic_pkg::PIC_DLY_ZERO,
            pic_pkg::PIC_DLY_FULL};
        {psel, penable, pwrite, paddr, pwdata, storeClk, outClk, globalSetReset} = '0;
        {outData, drvLvl, n_fail, samples_checked, arst_n} = '0;
        {pstrb, cellClockEnable, outTristate, drvOn} = 7'h7f;
        tick(16);
        arst_n <= 1'b1;
        tick(1);
        apb(1'b1, 12'h004, 32'hffff_ffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_3238);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        pin(1'b1);
        chk({firstArrayInput, secondArrayInput}, 2'b10);
        pulse();
        chk(secondArrayInput, 1'b1);
        pin(1'b0);
        chk({firstArrayInput, secondArrayInput}, 2'b01);
        cellClockEnable <= 1'b0;
        pulse();
        chk(secondArrayInput, 1'b1);
        wr(32'h0000_3230);
        pulse();
        chk(secondArrayInput, 1'b0);
        wr(32'h0000_3218);
        pin(1'b1);
        pulse();
        chk(secondArrayInput, 1'b1);
        cellClockEnable <= 1'b1;
        wr(32'h0000_3239);
        storeClk <= 1'b1;
        pin(1'b0);
        tick(2);
        chk(secondArrayInput, 1'b0);
        pin(1'b1);
        tick(2);
        chk(secondArrayInput, 1'b1);
        storeClk <= 1'b0;
        pin(1'b0);
        tick(2);
        chk(secondArrayInput, 1'b1);
        storeClk <= 1'b1;
        tick(4);
        wr(32'h0000_323a);
        pin(1'b1);
        chk(secondArrayInput, 1'b0);
        storeClk <= 1'b0;
        tick(4);
        chk(secondArrayInput, 1'b1);
        globalSetReset <= 1'b1;
        tick(3);
        chk(secondArrayInput, 1'b0);
        wr(32'h0000_327a);
        pulse();
        chk(secondArrayInput, 1'b1);
        globalSetReset <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            wr(32'h0000_3238 | (32'(d) << 10));
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[6:5], dx[d]);
        end
        wr(32'h0000_2238);
        {outTristate, outData, drvOn} <= 3'h2;
        tick(6);
        chk({pinOe, pinOut, firstArrayInput}, 3'h6);
        outTristate <= 1'b1;
        tick(2);
        chk(pinOe, 1'b0);
        print_verdict();
    end
endmodule
